// [frab_defs.vh]
// Constants for the file-register ALU and branch execution block.
// Assumes inclusion by frab_top.v and frab_alu.v only.
// Notes on behaviour
// RULE1 - Bump-and-skip writes sum, flags untouched
// RULE2 - Zero sum squashes next instruction, two cycles
// RULE3 - Jump loads immediate, latch bits 6:3 upper
// RULE4 - Jump takes two cycles, flags untouched
// RULE5 - OR immediate into accumulator, zero flag
// RULE6 - Bump writes sum, updates zero, never skips
// RULE7 - OR accumulator with register, zero flag
// RULE8 - Shift up: bit7 to carry, zero in
// RULE9 - Destination 0 accumulator, 1 register
// RULE10 - Zero flag set when result zero
// RULE11 - Non-skipping ALU operations take one cycle
`ifndef FRAB_DEFS_VH
`define FRAB_DEFS_VH

// ****************************************
// Operation codes
// ****************************************
`define FRAB_OP_NONE     3'h0
`define FRAB_OP_BUMP_SKP 3'h1
`define FRAB_OP_BUMP     3'h2
`define FRAB_OP_JUMP     3'h3
`define FRAB_OP_OR_IMM   3'h4
`define FRAB_OP_OR_REG   3'h5
`define FRAB_OP_SHIFT_UP 3'h6

// ****************************************
// Field positions and reset values
// ****************************************
`define FRAB_DEST_ACC    1'b0
`define FRAB_DEST_REG    1'b1
`define FRAB_LATCH_HI    6
`define FRAB_LATCH_LO    3
`define FRAB_ACC_RST     8'h00
`define FRAB_PC_RST      15'h0000
`define FRAB_FLAG_RST    1'b0

`endif

// [frab_alu.v]
// Combinational result and flag calculation for the ALU operations.
// Assumes operands are stable for the cycle the operation is presented.
`timescale 1ns/10ps
`include "frab_defs.vh"

module frab_alu #(
  parameter W = 8
) (
  input  wire [2:0]   op,
  input  wire [W-1:0] acc,
  input  wire [W-1:0] reg_val,
  input  wire [W-1:0] imm,
  output reg  [W-1:0] result,
  output reg          carry_out,
  output wire         zero_out
);

  always @* begin
    result    = {W{1'b0}};
    carry_out = 1'b0;
    case (op)
      `FRAB_OP_BUMP_SKP,
      `FRAB_OP_BUMP: begin
        result = reg_val + {{(W-1){1'b0}}, 1'b1}; // RULE1 RULE6
      end
      `FRAB_OP_OR_IMM: begin
        result = acc | imm; // RULE5
      end
      `FRAB_OP_OR_REG: begin
        result = acc | reg_val; // RULE7
      end
      `FRAB_OP_SHIFT_UP: begin
        result    = {reg_val[W-2:0], 1'b0}; // RULE8
        carry_out = reg_val[W-1]; // RULE8
      end
      default: begin
        result = {W{1'b0}};
      end
    endcase
  end

  assign zero_out = (result == {W{1'b0}}); // RULE10

endmodule // frab_alu

// [frab_top.v]
// Executes bump, bump-and-skip, OR, shift-up and absolute jump.
// Assumes decode presents one instruction per accepted cycle on op_valid
// and that the data file answers reg_rd_data combinationally for reg_addr.
`timescale 1ns/10ps
`include "frab_defs.vh"

module frab_top #(
  parameter W     = 8,
  parameter AW    = 7,
  parameter KW    = 11,
  parameter PCW   = 15,
  parameter LW    = 7
) (
  input  wire           clk,
  input  wire           srst,
  input  wire           op_valid,
  output wire           op_ready,
  input  wire [2:0]     op,
  input  wire [AW-1:0]  reg_addr,
  input  wire           dest_sel,
  input  wire [W-1:0]   imm_lit,
  input  wire [KW-1:0]  imm_jump,
  input  wire [LW-1:0]  upper_jump_latch,
  input  wire [W-1:0]   reg_rd_data,
  output reg            reg_wr_en,
  output reg  [AW-1:0]  reg_wr_addr,
  output reg  [W-1:0]   reg_wr_data,
  output reg  [W-1:0]   acc,
  output reg            zero_flag,
  output reg            carry_flag,
  output reg  [PCW-1:0] pc,
  output reg            pc_load,
  output reg            squash_next,
  output reg            done
);

  // ****************************************
  // State machine
  // ****************************************
  localparam ST_RUN   = 2'b01;
  localparam ST_STALL = 2'b10;

  reg  [1:0]   state;
  reg  [1:0]   next_state;
  wire [W-1:0] alu_result;
  wire         alu_carry;
  wire         alu_zero;

  // ****************************************
  // Operation decode
  // ****************************************
  // Operations that read the addressed file register
  function op_reads_file;
    input [2:0] code;
    begin
      op_reads_file = (code == `FRAB_OP_BUMP_SKP) ||
                      (code == `FRAB_OP_BUMP) ||
                      (code == `FRAB_OP_OR_REG) ||
                      (code == `FRAB_OP_SHIFT_UP);
    end
  endfunction

  // Operations that produce an eight-bit result
  function op_uses_alu;
    input [2:0] code;
    begin
      op_uses_alu = op_reads_file(code) || (code == `FRAB_OP_OR_IMM);
    end
  endfunction

  // Bump-and-skip is the one result op that leaves the flags alone
  function op_updates_zero;
    input [2:0] code;
    begin
      op_updates_zero = op_uses_alu(code) && (code != `FRAB_OP_BUMP_SKP); // RULE1
    end
  endfunction

  // Jump always, bump-and-skip only when its sum wraps to zero
  function op_needs_stall;
    input [2:0] code;
    input       sum_zero;
    begin
      op_needs_stall = (code == `FRAB_OP_JUMP) ||
                       ((code == `FRAB_OP_BUMP_SKP) && sum_zero); // RULE2 RULE4
    end
  endfunction

  // ****************************************
  // Result unit
  // ****************************************
  frab_alu #(
    .W         (W)
  ) u_alu (
    .op        (op),
    .acc       (acc),
    .reg_val   (reg_rd_data),
    .imm       (imm_lit),
    .result    (alu_result),
    .carry_out (alu_carry),
    .zero_out  (alu_zero)
  );

  // ****************************************
  // Handshake and decode signals
  // ****************************************
  assign op_ready = (state == ST_RUN);

  wire take      = op_valid & op_ready;
  wire is_skp    = (op == `FRAB_OP_BUMP_SKP);
  wire is_jump   = (op == `FRAB_OP_JUMP);
  wire is_alu    = op_uses_alu(op);
  wire upd_zero  = op_updates_zero(op);
  wire upd_carry = (op == `FRAB_OP_SHIFT_UP);
  wire to_reg    = op_reads_file(op) && (dest_sel == `FRAB_DEST_REG); // RULE9
  wire two_cyc   = op_needs_stall(op, alu_zero); // RULE2 RULE4
  wire do_alu    = take & is_alu;
  wire do_jump   = take & is_jump;

  // Upper counter bits come from latch bits 6:3
  wire [PCW-1:0] jump_target = {upper_jump_latch[`FRAB_LATCH_HI:`FRAB_LATCH_LO],
                                imm_jump}; // RULE3

  // ****************************************
  // Next-state logic
  // ****************************************
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (take && two_cyc) begin
          next_state = ST_STALL; // RULE2 RULE4
        end
      end
      ST_STALL: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Accumulator and flags
  // ****************************************
  reg [W-1:0] next_acc;
  reg         next_zero;
  reg         next_carry;

  always @* begin
    next_acc   = acc;
    next_zero  = zero_flag;
    next_carry = carry_flag;
    if (do_alu) begin
      if (!to_reg) begin
        next_acc = alu_result; // RULE5 RULE9
      end
      if (upd_zero) begin
        next_zero = alu_zero; // RULE6 RULE7 RULE10
      end
      if (upd_carry) begin
        next_carry = alu_carry; // RULE8
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      acc        <= `FRAB_ACC_RST;
      zero_flag  <= `FRAB_FLAG_RST;
      carry_flag <= `FRAB_FLAG_RST;
    end else begin
      acc        <= next_acc;
      zero_flag  <= next_zero;
      carry_flag <= next_carry;
    end
  end

  // ****************************************
  // File register write port
  // ****************************************
  wire next_wr_en = do_alu & to_reg; // RULE9

  always @(posedge clk) begin
    if (srst) begin
      reg_wr_en   <= 1'b0;
      reg_wr_addr <= {AW{1'b0}};
      reg_wr_data <= {W{1'b0}};
    end else begin
      reg_wr_en <= next_wr_en;
      if (next_wr_en) begin
        reg_wr_addr <= reg_addr; // RULE9
        reg_wr_data <= alu_result; // RULE1 RULE6 RULE7 RULE8
      end
    end
  end

  // ****************************************
  // Program counter
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      pc      <= `FRAB_PC_RST;
      pc_load <= 1'b0;
    end else begin
      pc_load <= do_jump; // RULE3
      if (do_jump) begin
        pc <= jump_target; // RULE3
      end
    end
  end

  // ****************************************
  // Completion and squash pulses
  // ****************************************
  wire next_squash = take & is_skp & alu_zero; // RULE2
  wire next_done   = (state == ST_STALL) | (do_alu & ~two_cyc); // RULE4 RULE11

  always @(posedge clk) begin
    if (srst) begin
      squash_next <= 1'b0;
      done        <= 1'b0;
    end else begin
      squash_next <= next_squash;
      done        <= next_done;
    end
  end

endmodule // frab_top

// [frab_chk.sv]
// Port checker for the ALU and jump block.
// Assumes it is bound onto frab_top.
`timescale 1ns/10ps
// ****
// Checker
// ****
module frab_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic        dest_sel,
  input wire logic        done,
  input wire logic [2:0]  op,
  input wire logic [7:0]  reg_rd_data,
  input wire logic [7:0]  imm_lit,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  reg_wr_data,
  input wire logic [10:0] imm_jump,
  input wire logic [6:0]  upper_jump_latch,
  input wire logic [14:0] pc,
  input wire logic        reg_wr_en,
  input wire logic        zero_flag,
  input wire logic        carry_flag,
  input wire logic        pc_load,
  input wire logic        squash_next
);
  wire fire = op_valid && op_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_skip_flags: assert property (fire && op == 3'h1 |=> $stable({zero_flag, carry_flag}))
    else $error("flags moved on skip op");
  a_skip_squash: assert property (fire && op == 3'h1 |=> squash_next == ($past(reg_rd_data) == 8'hff))
    else $error("squash wrong");
  a_jump_two: assert property (fire && op == 3'h3 |=> pc_load && !op_ready ##1 done)
    else $error("jump timing wrong");
  a_or_imm: assert property (fire && op == 3'h4 |=> acc == ($past(acc) | $past(imm_lit)))
    else $error("or literal wrong");
  a_bump_zero: assert property (fire && op == 3'h2 && dest_sel |=> reg_wr_en && !squash_next && zero_flag == (reg_wr_data == 8'h00))
    else $error("bump wrong");
  a_or_acc: assert property (fire && op == 3'h5 && !dest_sel |=> !reg_wr_en && acc == ($past(acc) | $past(reg_rd_data)))
    else $error("or register wrong");
  a_shift_carry: assert property (fire && op == 3'h6 |=> carry_flag == $past(reg_rd_data[7]))
    else $error("shift carry wrong");
  a_one_cycle: assert property (fire && (op == 3'h2 || op == 3'h5 || op == 3'h6) |=> done)
    else $error("op not done in one cycle");
  a_jump_target: assert property (fire && op == 3'h3 |=>
      pc == {$past(upper_jump_latch[6:3]), $past(imm_jump)})
    else $error("jump target wrong");
  a_jump_flags: assert property (fire && op == 3'h3 |=>
      $stable({zero_flag, carry_flag}) && !reg_wr_en)
    else $error("flags moved on jump");
  a_stall_refuse: assert property (!op_ready |=>
      op_ready && done && !pc_load && !reg_wr_en && !squash_next)
    else $error("op taken during stall");
  a_bump_wrap: assert property (fire && op == 3'h2 && dest_sel && reg_rd_data == 8'hff |=>
      reg_wr_en && reg_wr_data == 8'h00 && zero_flag)
    else $error("bump wrap wrong");
endmodule // frab_chk

bind frab_top frab_chk chk (.*);

// [test_frab_top.sv]
// Self-checking bench for frab_top.
// Assumes frab_chk.sv is compiled alongside.
`timescale 1ns/10ps
// ****
// Bench
// ****
module test_frab_top;
  logic        clk = 0, srst = 1, op_valid = 0, dest_sel = 0;
  logic [2:0]  op = 0;
  logic [6:0]  reg_addr = 0, upper_jump_latch = 0, reg_wr_addr;
  logic [7:0]  imm_lit = 0, reg_rd_data = 0, acc, reg_wr_data, m_acc = 0, r;
  logic [10:0] imm_jump = 0;
  logic [14:0] pc, m_pc = 0;
  logic        m_z = 0, m_c = 0, reg_wr_en, zero_flag, carry_flag, done;
  logic [24:0] eq[$];
  logic [14:0] wq[$];
  int          failures = 0, n_tests = 0;
  frab_top uut (.clk(clk), .srst(srst), .op_valid(op_valid), .op_ready(), .op(op),
    .reg_addr(reg_addr), .dest_sel(dest_sel), .imm_lit(imm_lit), .imm_jump(imm_jump),
    .upper_jump_latch(upper_jump_latch), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .acc(acc), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .pc(pc), .pc_load(), .squash_next(), .done(done));
  initial forever #2.5 clk = ~clk;
  task chk(input bit ok);
    n_tests++;
    if (!ok) begin
      failures++;
      $display("CHECK FAILED %0t result mismatch", $time);
    end
  endtask
  task wrap_up;
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Model one op, queue its results, drive it
  task run(input logic [2:0] o, input logic d);
    logic [7:0]  rd, lt;
    logic [6:0]  ad, la;
    logic [10:0] jp;
    logic        two, alu;
    rd = $urandom % 3 == 0 ? 8'hff : ($urandom % 2 ? 8'h00 : 8'($urandom));
    ad = 7'($urandom);
    lt = 8'($urandom);
    la = 7'($urandom);
    jp = 11'($urandom);
    alu = o > 0 && o < 7 && o != 3'h3;
    two = o == 3'h3;
    case (o)
      3'h1, 3'h2: r = rd + 8'h01;
      3'h3: m_pc = {la[6:3], jp};
      3'h4: r = m_acc | lt;
      3'h5: r = m_acc | rd;
      3'h6: begin
        r = {rd[6:0], 1'b0};
        m_c = rd[7];
      end
      default: r = 8'h00;
    endcase
    if (o == 3'h1) two = r == 8'h00;
    else if (alu) m_z = r == 8'h00;
    if (alu && d && o != 3'h4) wq.push_back({ad, r});
    else if (alu) m_acc = r;
    if (o > 0 && o < 7) eq.push_back({m_acc, m_z, m_c, m_pc});
    op_valid <= 1'b1;
    op <= o;
    dest_sel <= d;
    reg_addr <= ad;
    imm_lit <= lt;
    imm_jump <= jp;
    upper_jump_latch <= la;
    reg_rd_data <= rd;
    @(posedge clk);
    if (two) begin
      op <= 3'h4;
      @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    #1;
    if (done === 1'b1) chk(eq.size() > 0 && eq.pop_front() === {acc, zero_flag, carry_flag, pc});
    if (reg_wr_en === 1'b1) chk(wq.size() > 0 && wq.pop_front() === {reg_wr_addr, reg_wr_data});
  end
  initial begin
    void'($urandom(32'hb3a0));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (400) run(3'($urandom), 1'($urandom));
    op_valid <= 1'b0;
    repeat (4) @(posedge clk);
    chk(eq.size() == 0 && wq.size() == 0);
    wrap_up;
  end
endmodule // test_frab_top
